//--- design/csu_chip_select.v
// Purpose: four-line chip-select decode with acknowledge wait-state generator
// Assumes: bus inputs synchronous to ref_clk; registers reached over the bus
// Notes: select lines and zero-wait acknowledge are combinational
//
// How it works
// - ack code 0-6 waits, 7 external
// - code 7: never drive acknowledge
// - ack field resets to six waits
// - waits counted on internal clock always
// - zero waits: acknowledge straight from decode
// - mask bits pick compared address bits
// - mask bits independent, aliases allowed
// - mask resets all ones, 8K block
// - direction mask off: reads and writes
// - space compare bit, resets to one
// - space code 111 never selects
// - 32-bit control register at 0F4, space 5
// - base register field layout
// - lowest line wins; internal space selects none
// - write to read-only: flag, bus error
// - acknowledge only with an asserted select or an internal register cycle
`timescale 1ns/100ps
`default_nettype none
`include "csu_regs.vh"

module csu_chip_select
(
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // bus cycle from the active master
    input wire [23:1] busAddr,
    input wire [2:0] busFc,
    input wire busAsN,
    input wire busRdWr,
    input wire busExtMaster,
    // register data bus
    input wire [15:0] busDataIn,
    output reg [15:0] busDataOut_r,
    output wire busDataOeN,
    // select lines, active low
    output wire [3:0] selectLinesN,
    // acknowledge pin, active low
    output wire dtackOut,
    output wire dtackOeN,
    // bus error pin, active low
    output wire berrOut,
    output wire berrOeN
);

    // ***************************************************************
    // functions
    // ***************************************************************

    // lowest numbered set bit only
    function [3:0] firstOne;
        input [3:0] v;
        begin
            firstOne = v & (~v + 4'h1);
        end
    endfunction

    // effective wait count with optional external-master extra
    function [2:0] waitsFor;
        input [2:0] code;
        input extra;
        begin
            waitsFor = code + {2'h0, extra};
        end
    endfunction

    // ***************************************************************
    // state
    // ***************************************************************
    reg [15:0] baseReg_r [0:3];
    reg [15:0] optReg_r [0:3];
    reg [31:0] sysCtrl_r;
    reg asPrev_r;
    reg [2:0] waitCnt_r;
    reg [2:0] waitCnt_nxt;
    reg [7:0] status_nxt;
    reg [7:0] statClr;

    wire [23:0] byteAddr;
    wire isWrite;
    wire cycOn;
    wire asStart;
    wire selPageHit;
    wire scrHiHit;
    wire scrLoHit;
    wire intHit;
    wire [1:0] lineIdx;
    wire [3:0] lineHits;
    wire [3:0] wpHits;
    wire [3:0] grant;
    wire anySel;
    wire conflict;
    wire wpAny;
    wire [2:0] ackCode;
    wire extraWait;
    wire [2:0] waitNeed;
    wire lineAck;
    wire intAck;
    wire regWrite;

    // ***************************************************************
    // cycle decode
    // ***************************************************************
    assign byteAddr = {busAddr, 1'b0};
    assign isWrite = !busRdWr;
    assign cycOn = !busAsN;
    // first clock of a strobe: one-shot for writes and events
    assign asStart = cycOn & asPrev_r;
    assign selPageHit = byteAddr[23:`CSU_SEL_PAGE_LSB] == `CSU_SEL_PAGE;
    assign scrHiHit = byteAddr == `CSU_SCR_HI_ADDR;
    assign scrLoHit = byteAddr == `CSU_SCR_LO_ADDR;
    assign intHit = (busFc == `CSU_REG_FC)
                    && (selPageHit || scrHiHit || scrLoHit);
    assign lineIdx = byteAddr[3:2];
    assign regWrite = asStart & intHit & isWrite;

    // ***************************************************************
    // per-line compare
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : gLine
            csu_line_match uMatch
            (
                .baseReg(baseReg_r[g]),
                .optReg(optReg_r[g]),
                .busAddrHi(busAddr[23:13]),
                .busFc(busFc),
                .isWrite(isWrite),
                .lineHit(lineHits[g]),
                .writeProtViol(wpHits[g])
            );
        end
    endgenerate

    // internal space masks every line; line 0 outranks the rest
    assign grant = intHit ? 4'h0 : firstOne(lineHits);
    assign anySel = grant != 4'h0;
    assign selectLinesN = ~(grant & {4{cycOn}});
    // more than one line hit; config register cycles never count
    assign conflict = !intHit && (lineHits != firstOne(lineHits));
    assign wpAny = !intHit && (wpHits != 4'h0);

    // ***************************************************************
    // acknowledge generation
    // ***************************************************************
    assign ackCode = grant[0] ? optReg_r[0][`CSU_OPT_ACK_HI:`CSU_OPT_ACK_LO] :
                     grant[1] ? optReg_r[1][`CSU_OPT_ACK_HI:`CSU_OPT_ACK_LO] :
                     grant[2] ? optReg_r[2][`CSU_OPT_ACK_HI:`CSU_OPT_ACK_LO] :
                                optReg_r[3][`CSU_OPT_ACK_HI:`CSU_OPT_ACK_LO];
    assign extraWait = busExtMaster & sysCtrl_r[`CSU_SCR_EXT_MASTER_EXTRA_WAIT];
    assign waitNeed = waitsFor(ackCode, extraWait);
    // code zero without the external-master extra wait compares against a zero count: no clock edge needed
    assign lineAck = cycOn && anySel && (ackCode != `CSU_ACK_EXTERNAL)
                     && (waitCnt_r >= waitNeed);
    // register reads need one edge for the data flop
    assign intAck = cycOn && intHit && (waitCnt_r != 3'h0);
    assign dtackOut = 1'b0;
    assign dtackOeN = !(lineAck || intAck);

    // bus error is held for the rest of the offending cycle
    assign berrOut = 1'b0;
    assign berrOeN = !(cycOn && ((wpAny && sysCtrl_r[`CSU_SCR_WRITE_PROTECT_ERROR_ENABLE])
                     || (conflict && sysCtrl_r[`CSU_SCR_ADCE])));

    assign busDataOeN = !(cycOn && intHit && busRdWr);

    // wait counter: edges of ref_clk since strobe, also for async masters
    always @*
    begin
        waitCnt_nxt = 3'h0;
        if (cycOn && (anySel || intHit) && waitCnt_r != `CSU_CNT_MAX)
            waitCnt_nxt = waitCnt_r + 3'h1;
        else if (cycOn && (anySel || intHit))
            waitCnt_nxt = waitCnt_r;
    end

    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            waitCnt_r <= 3'h0;
            asPrev_r <= 1'b1;
        end
        else
        begin
            waitCnt_r <= waitCnt_nxt;
            asPrev_r <= busAsN;
        end
    end

    // ***************************************************************
    // register file
    // ***************************************************************

    // status bits clear by one; a same-cycle event wins over the clear
    always @*
    begin
        statClr = 8'h00;
        if (regWrite && scrHiHit)
            statClr = busDataIn[15:8];
        status_nxt = sysCtrl_r[31:24] & ~statClr;
        if (asStart && wpAny)
            status_nxt[`CSU_SCR_WPV - 24] = 1'b1;
        if (asStart && conflict)
            status_nxt[`CSU_SCR_ADC - 24] = 1'b1;
    end

    integer i;
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                baseReg_r[i] <= (i == 0) ? `CSU_BASE0_RST : `CSU_BASE_RST;
                optReg_r[i] <= `CSU_OPT_RST;
            end
            sysCtrl_r <= `CSU_SCR_RST;
        end
        else
        begin
            sysCtrl_r[31:24] <= status_nxt;
            if (regWrite && scrHiHit)
                sysCtrl_r[23:16] <= busDataIn[7:0];
            if (regWrite && scrLoHit)
                sysCtrl_r[15:0] <= busDataIn;
            if (regWrite && selPageHit && !byteAddr[1])
                baseReg_r[lineIdx] <= busDataIn;
            if (regWrite && selPageHit && byteAddr[1])
                optReg_r[lineIdx] <= busDataIn;
        end
    end

    // read data captured on every clock of a register cycle into the output flop
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            busDataOut_r <= 16'h0000;
        else if (cycOn && intHit)
        begin
            if (scrHiHit)
                busDataOut_r <= sysCtrl_r[31:16];
            else if (scrLoHit)
                busDataOut_r <= sysCtrl_r[15:0];
            else if (byteAddr[1])
                busDataOut_r <= optReg_r[lineIdx];
            else
                busDataOut_r <= baseReg_r[lineIdx];
        end
    end

endmodule // csu_chip_select
`default_nettype wire

//--- design/csu_regs.vh
// Purpose: constants for the chip-select option decode unit
// Assumes: 24-bit byte address, 16-bit data bus, word-wide register access
// Notes: all offsets are byte addresses in supervisor data space
`ifndef CSU_REGS_VH
`define CSU_REGS_VH

// ***************************************************************
// register placement
// ***************************************************************
`define CSU_REG_FC 3'h5
`define CSU_SCR_HI_ADDR 24'h0000F4
`define CSU_SCR_LO_ADDR 24'h0000F6
`define CSU_SEL_PAGE 20'h00083
`define CSU_SEL_PAGE_LSB 4

// ***************************************************************
// field positions
// ***************************************************************
`define CSU_OPT_ACK_HI 15
`define CSU_OPT_ACK_LO 13
`define CSU_MASK_HI 12
`define CSU_MASK_LO 2
`define CSU_OPT_RWMASK 1
`define CSU_OPT_FCCMP 0
`define CSU_BASE_FC_HI 15
`define CSU_BASE_FC_LO 13
`define CSU_BASE_RW 1
`define CSU_BASE_EN 0
`define CSU_SCR_WPV 25
`define CSU_SCR_ADC 24
`define CSU_SCR_WRITE_PROTECT_ERROR_ENABLE 20
`define CSU_SCR_EXT_MASTER_EXTRA_WAIT 18
`define CSU_SCR_ADCE 17

// ***************************************************************
// codes and reset values
// ***************************************************************
`define CSU_ACK_EXTERNAL 3'h7
`define CSU_FC_IACK 3'h7
`define CSU_BASE0_RST 16'hC001
`define CSU_BASE_RST 16'hC000
`define CSU_OPT_RST 16'hDFFD
`define CSU_SCR_RST 32'h00000000
`define CSU_CNT_MAX 3'h7

`endif

//--- design/csu_line_match.v
// Purpose: address, space and direction compare for one select line
// Assumes: inputs stable while the address strobe is low
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "csu_regs.vh"

module csu_line_match
(
    // line programming
    input wire [15:0] baseReg,
    input wire [15:0] optReg,
    // bus cycle
    input wire [23:13] busAddrHi,
    input wire [2:0] busFc,
    input wire isWrite,
    // result
    output wire lineHit,
    output wire writeProtViol
);

    wire addrOk;
    wire fcOk;
    wire rwOk;
    wire placeOk;

    // each mask bit gates its own address bit, no contiguity assumed
    assign addrOk = ((busAddrHi ^ baseReg[`CSU_MASK_HI:`CSU_MASK_LO])
                    & optReg[`CSU_MASK_HI:`CSU_MASK_LO]) == 11'h000;
    // space code 111 never selects, even with compare off
    assign fcOk = (busFc != `CSU_FC_IACK) && (!optReg[`CSU_OPT_FCCMP]
                  || busFc == baseReg[`CSU_BASE_FC_HI:`CSU_BASE_FC_LO]);
    assign rwOk = !optReg[`CSU_OPT_RWMASK]
                  || (baseReg[`CSU_BASE_RW] == isWrite);
    assign placeOk = baseReg[`CSU_BASE_EN] & addrOk & fcOk;
    assign lineHit = placeOk & rwOk;
    // write into a read-only block: flagged, never selected
    assign writeProtViol = placeOk & optReg[`CSU_OPT_RWMASK]
                           & !baseReg[`CSU_BASE_RW] & isWrite;

endmodule // csu_line_match
`default_nettype wire

//--- test/csu_chip_select_checker.sv
// Purpose: port checks for the chip-select decode unit
// Assumes: one clock domain, reset active low
// Notes: bound into every csu_chip_select instance
`timescale 1ns/100ps
`default_nettype none

module csu_chip_select_checker
(
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // bus cycle
    input wire [23:1] busAddr,
    input wire [2:0] busFc,
    input wire busAsN,
    input wire busRdWr,
    input wire busDataOeN,
    // pins
    input wire [3:0] selectLinesN,
    input wire dtackOeN,
    input wire berrOeN
);
    // ****************************************
    // properties on the select, ack, bus error and data enable pins
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_one_line; $onehot0(~selectLinesN); endproperty
    property p_no_iack; busFc == 3'h7 |-> &selectLinesN; endproperty
    property p_idle; busAsN |-> dtackOeN && busDataOeN && (&selectLinesN); endproperty
    property p_ack_cause; !dtackOeN |-> !(&selectLinesN) || busFc == 3'h5; endproperty
    property p_ack_holds; !busAsN && !dtackOeN |=> busAsN || !dtackOeN; endproperty
    property p_berr_strobe; !berrOeN |-> !busAsN; endproperty
    property p_sel_steady; !busAsN && !$past(busAsN) && $stable(busAddr) && $stable(busFc)
        && $stable(busRdWr) |-> $stable(selectLinesN); endproperty
    property p_data_oe; !busDataOeN |-> busRdWr && busFc == 3'h5 && (&selectLinesN); endproperty
    // a register read answers one edge after the strobe start, never sooner
    property p_reg_ack; $fell(busAsN) && !busDataOeN |-> dtackOeN ##1 !dtackOeN; endproperty
    a_one_line: assert property (p_one_line) else $error("two select lines low");
    a_no_iack: assert property (p_no_iack) else $error("select in ack space");
    a_idle: assert property (p_idle) else $error("pin driven without strobe");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without select");
    a_ack_holds: assert property (p_ack_holds) else $error("ack dropped early");
    a_berr_strobe: assert property (p_berr_strobe) else $error("bus error idle");
    a_sel_steady: assert property (p_sel_steady) else $error("select moved");
    a_data_oe: assert property (p_data_oe) else $error("data driven wrongly");
    a_reg_ack: assert property (p_reg_ack) else $error("register ack timing");
    c_ack: cover property (!dtackOeN && !(&selectLinesN));
    c_berr: cover property (!berrOeN);
    c_reg: cover property (!busDataOeN && !dtackOeN);
endmodule // csu_chip_select_checker

bind csu_chip_select csu_chip_select_checker chk (.ref_clk(ref_clk), .nrst(nrst),
    .busAddr(busAddr), .busFc(busFc), .busAsN(busAsN), .busRdWr(busRdWr),
    .busDataOeN(busDataOeN), .selectLinesN(selectLinesN), .dtackOeN(dtackOeN),
    .berrOeN(berrOeN));
`default_nettype wire

//--- test/csu_ext_mem.sv
// Purpose: external memory on the select lines, acking by itself
// Assumes: told which lines leave the ack to it
// Notes: lag sets how slow the memory answers
`timescale 1ns/100ps
`default_nettype none

module csu_ext_mem
(
    // clock
    input wire logic ref_clk,
    // selects and setup
    input wire logic [3:0] selectLinesN,
    input wire logic [3:0] extLines,
    input wire logic [3:0] lag,
    // ack from the memory
    output logic extAck
);
    // ****************************************
    // wait count while selected
    // ****************************************
    logic [3:0] cnt = 4'h0;
    wire hit = |(~selectLinesN & extLines);
    // only lines left external get an ack, so both never fight the pin
    always @(posedge ref_clk)
        cnt <= hit ? cnt + 4'h1 : 4'h0;
    assign extAck = hit && cnt >= lag;
endmodule // csu_ext_mem
`default_nettype wire

//--- test/tb_top.sv
// Purpose: self-checking bench for the chip-select decode unit
// Assumes: 50 MHz clock, registers in supervisor data space
// Notes: a monitor compares each finished cycle with the driver's note
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    // ****************************************
    // clock, reset, pins
    // ****************************************
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [23:1] busAddr = 23'h0;
    logic [2:0] busFc = 3'h0;
    logic busAsN = 1'b1;
    logic busRdWr = 1'b1;
    logic busExtMaster = 1'b0;
    logic [15:0] busDataIn = 16'h0;
    logic [3:0] ext = 4'h0;
    logic [3:0] lag = 4'h1;
    wire [15:0] rdData;
    wire [3:0] selectLinesN;
    wire dtackOeN;
    wire berrOeN;
    wire extAck;
    int mismatches = 0;
    int comparisons = 0;
    logic [25:0] notes[$];
    logic be = 1'b0;
    logic expBerr = 1'b0;
    logic [10:0] b;
    logic [23:0] A;
    logic run = 1'b0;
    logic got = 1'b0;
    logic [3:0] w = 4'h0;
    logic [3:0] sel;
    logic [15:0] rd;
    logic [25:0] nt;

    initial
        forever #10 ref_clk = ~ref_clk;

    csu_chip_select dut (.ref_clk(ref_clk), .nrst(nrst), .busAddr(busAddr), .busFc(busFc),
        .busAsN(busAsN), .busRdWr(busRdWr), .busExtMaster(busExtMaster),
        .busDataIn(busDataIn), .busDataOut_r(rdData), .busDataOeN(),
        .selectLinesN(selectLinesN), .dtackOut(), .dtackOeN(dtackOeN), .berrOut(),
        .berrOeN(berrOeN));
    csu_ext_mem mem (.ref_clk(ref_clk), .selectLinesN(selectLinesN), .extLines(ext),
        .lag(lag), .extAck(extAck));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task report_and_stop;
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one note per cycle: {bus error, check data, selects, waits, data}; waits F means no ack
    always @(posedge ref_clk)
        if (!busAsN)
        begin
            if (!run)
                sel = selectLinesN;
            run = 1'b1;
            if (!dtackOeN && !got)
                rd = rdData;
            got = got | !dtackOeN;
            be = be | !berrOeN;
            if (!got)
                w = w + 4'h1;
        end
        else if (run)
        begin
            nt = notes.pop_front();
            check("select", {12'h0, sel}, {12'h0, nt[23:20]});
            check("waits", {12'h0, got ? w : 4'hF}, {12'h0, nt[19:16]});
            check("berr", {15'h0, be}, {15'h0, nt[25]});
            if (nt[24])
                check("data", rd, nt[15:0]);
            run = 1'b0;
            got = 1'b0;
            be = 1'b0;
            w = 4'h0;
        end

    // ****************************************
    // bus cycles
    // ****************************************
    // holds the strobe until an ack, or 12 cycles when none may come
    task automatic cyc(input logic [23:0] a, input logic [2:0] f, input logic r,
        input logic [15:0] d, input logic [23:0] e, input logic c);
        int n;
        n = 0;
        notes.push_back({expBerr, c, e});
        @(posedge ref_clk);
        busAddr <= a[23:1];
        busFc <= f;
        busRdWr <= r;
        busDataIn <= d;
        busAsN <= 1'b0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (dtackOeN && !extAck && n < 12);
        @(posedge ref_clk);
        busAsN <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        cyc(a, 3'h5, 1'b0, d, {4'hF, 4'h1, 16'h0}, 1'b0);
    endtask

    task automatic rdr(input logic [23:0] a, input logic [15:0] e);
        cyc(a, 3'h5, 1'b1, 16'h0, {4'hF, 4'h1, e}, 1'b1);
    endtask

    task automatic la(input logic [23:0] a, input logic [2:0] f, input logic r,
        input logic [3:0] s, input logic [3:0] wt);
        cyc(a, f, r, 16'h0, {s, wt, 16'h0}, 1'b0);
    endtask

    initial
    begin
        #100000;
        mismatches++;
        report_and_stop;
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        A = $urandom(32'hBD672695);
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rdr(24'h0000F4, 16'h0000);
        rdr(24'h000832, 16'hDFFD);
        rdr(24'h000830, 16'hC001);
        A = ($urandom & 24'h001FFE) | 24'h001000;
        la(A, 3'h6, 1'b1, 4'hE, 4'h6);
        la(A | 24'h002000, 3'h6, 1'b1, 4'hF, 4'hF);
        b = ($urandom & 11'h3FF) | 11'h400;
        A = {b, 13'h0} | ($urandom & 24'h001FFE);
        // base kept on an 8K boundary, as software must place it
        wr(24'h000834, {3'h5, b, 2'b01});
        for (int k = 0; k < 8; k++)
        begin
            ext <= {2'b00, k == 7, 1'b0};
            lag <= 4'h1 + ($urandom & 4'h3);
            wr(24'h000836, {k[2:0], 11'h7FF, 2'b00});
            la(A, 3'h1, 1'b1, 4'hD, k == 7 ? 4'hF : k[3:0]);
        end
        ext <= 4'h0;
        wr(24'h000836, {3'h2, 11'h3FF, 2'b00});
        la(A, 3'h7, 1'b1, 4'hF, 4'hF);
        la(A ^ 24'h800000, 3'h2, 1'b1, 4'hD, 4'h2);
        wr(24'h0000F4, 16'h0004);
        busExtMaster <= 1'b1;
        la(A, 3'h1, 1'b1, 4'hD, 4'h3);
        busExtMaster <= 1'b0;
        wr(24'h0000F4, 16'h0010);
        wr(24'h000836, {3'h2, 11'h7FF, 2'b10});
        expBerr = 1'b1;
        la(A, 3'h1, 1'b0, 4'hF, 4'hF);
        expBerr = 1'b0;
        rdr(24'h0000F4, 16'h0210);
        la(A, 3'h1, 1'b1, 4'hD, 4'h2);
        // line 2 overlaps line 1: the lower number wins, conflict flagged
        wr(24'h000838, {3'h1, b, 2'b01});
        la(A, 3'h1, 1'b1, 4'hD, 4'h2);
        rdr(24'h0000F4, 16'h0310);
        // status cleared by ones, bus error on conflict enabled
        wr(24'h0000F4, 16'h0312);
        rdr(24'h0000F4, 16'h0012);
        expBerr = 1'b1;
        la(A, 3'h1, 1'b1, 4'hD, 4'h2);
        expBerr = 1'b0;
        repeat (2) @(posedge ref_clk);
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
